// [verilog/cwd_params.svh]
// constants for the card window enable and i/o decode block
`ifndef CWD_PARAMS_SVH
`define CWD_PARAMS_SVH
`define CWD_SOCKET_BASE 12'h800
`define CWD_OFF_ENABLE 8'h06
`define CWD_OFF_IOCTL 8'h07
`define CWD_OFF_IO0_SL 8'h08
`define CWD_OFF_IO0_SH 8'h09
`define CWD_OFF_IO0_EL 8'h0A
`define CWD_OFF_IO0_EH 8'h0B
`define CWD_OFF_IO1_SL 8'h0C
`define CWD_OFF_IO1_SH 8'h0D
`define CWD_OFF_IO1_EL 8'h0E
`define CWD_OFF_IO1_EH 8'h0F
`define CWD_RESET_BYTE 8'h00
`define CWD_ENABLE_WMASK 8'hDF
`define CWD_BIT_IO1_ON 7
`define CWD_BIT_IO0_ON 6
`define CWD_BIT_RSVD 5
`define CWD_CTL_IO1_LSB 4
`define CWD_CTL_IO0_LSB 0
`define CWD_BIT_EXTRA_WAIT 3
`define CWD_BIT_SHORT 2
`define CWD_BIT_FROM_CARD 1
`define CWD_BIT_WIDE 0
`define CWD_ISA_8_STD 3'h4
`define CWD_ISA_8_SHORT 3'h3
`define CWD_ISA_16_STD 3'h2
`define CWD_ISA_16_LONG 3'h3
`endif

// [verilog/cwd_pkg.sv]
// types for the card window enable and i/o decode block
package cwd_pkg;
  typedef struct packed {
    logic io1_extra_wait;
    logic io1_short_cycle;
    logic io1_width_from_card;
    logic io1_wide_select;
    logic io0_extra_wait;
    logic io0_short_cycle;
    logic io0_width_from_card;
    logic io0_wide_select;
  } cwd_ioctl_type;
  typedef struct packed {
    logic [15:0] start_addr;
    logic [15:0] end_addr;
  } cwd_range_type;
  typedef struct packed {
    logic hit;
    logic window;
    logic wide;
    logic [2:0] isa_cycles;
  } cwd_claim_type;
endpackage

// [verilog/cwd_range_match.sv]
// inclusive address range compare for one i/o window
`timescale 1ns/1ps
module cwd_range_match (
  input wire logic on,
  input wire cwd_pkg::cwd_range_type range,
  input wire logic [15:0] addr,
  output logic hit
);
  import cwd_pkg::*;
  // both bounds included
  assign hit = on && (addr >= range.start_addr) && (addr <= range.end_addr);
endmodule // cwd_range_match

// [verilog/cwd_cycle_timing.sv]
// width and isa cycle length selection for one i/o window
`timescale 1ns/1ps
`include "cwd_params.svh"
module cwd_cycle_timing (
  input wire logic [3:0] ctl,
  input wire logic card_is16,
  output logic wide,
  output logic [2:0] isa_cycles
);
  import cwd_pkg::*;
  // width follows card pin when the source bit is set
  assign wide = ctl[`CWD_BIT_FROM_CARD] ? card_is16 : ctl[`CWD_BIT_WIDE];
  always_comb begin
    if (wide) begin
      isa_cycles = ctl[`CWD_BIT_EXTRA_WAIT] ? `CWD_ISA_16_LONG : `CWD_ISA_16_STD;
    end else begin
      isa_cycles = ctl[`CWD_BIT_SHORT] ? `CWD_ISA_8_SHORT : `CWD_ISA_8_STD;
    end
  end
endmodule // cwd_cycle_timing

// [verilog/cwd_window_regs.sv]
// window enable, i/o control and i/o address registers with i/o window decode
`timescale 1ns/1ps
`include "cwd_params.svh"
module cwd_window_regs (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic io_req,
  input wire logic [15:0] io_addr,
  input wire logic card_is16_pin,
  output cwd_pkg::cwd_claim_type io_claim,
  output logic [4:0] mem_window_on
);
  import cwd_pkg::*;

  logic [7:0] window_enable;
  cwd_ioctl_type io_window_control;
  logic [7:0] addr_byte [0:7];
  logic [7:0] local_off;
  logic in_block;
  logic is16_meta;
  logic is16_sync;
  logic [1:0] win_hit;
  logic [1:0] win_wide;
  logic [2:0] win_cycles [0:1];
  cwd_range_type range [0:1];
  cwd_claim_type next_claim;
  logic [7:0] next_rdata;

  // decode only offsets 06h..0Fh above the socket base
  assign in_block = (reg_addr[11:8] == 4'(`CWD_SOCKET_BASE >> 8));
  assign local_off = reg_addr[7:0];
  assign reg_hit = reg_sel && in_block && (local_off >= `CWD_OFF_ENABLE)
                   && (local_off <= `CWD_OFF_IO1_EH);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      window_enable <= `CWD_RESET_BYTE;
    end else if (reg_hit && reg_wr && local_off == `CWD_OFF_ENABLE) begin
      window_enable <= reg_wdata & `CWD_ENABLE_WMASK;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      io_window_control <= cwd_ioctl_type'(`CWD_RESET_BYTE);
    end else if (reg_hit && reg_wr && local_off == `CWD_OFF_IOCTL) begin
      io_window_control <= cwd_ioctl_type'(reg_wdata);
    end
  end

  // eight address bytes, 08h..0Fh, indexed by the low three offset bits
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_addr
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          addr_byte[gi] <= `CWD_RESET_BYTE;
        end else if (reg_hit && reg_wr
                     && local_off == (`CWD_OFF_IO0_SL + 8'(gi))) begin
          addr_byte[gi] <= reg_wdata;
        end
      end
    end
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_win
      assign range[gi].start_addr = {addr_byte[4*gi+1], addr_byte[4*gi]};
      assign range[gi].end_addr = {addr_byte[4*gi+3], addr_byte[4*gi+2]};
      cwd_range_match u_match (
        .on(window_enable[`CWD_BIT_IO0_ON + gi]),
        .range(range[gi]),
        .addr(io_addr),
        .hit(win_hit[gi])
      );
      cwd_cycle_timing u_timing (
        .ctl(io_window_control[4*gi +: 4]),
        .card_is16(is16_sync),
        .wide(win_wide[gi]),
        .isa_cycles(win_cycles[gi])
      );
    end
  endgenerate

  always_comb begin
    next_rdata = `CWD_RESET_BYTE;
    if (local_off == `CWD_OFF_ENABLE) begin
      next_rdata = window_enable;
    end else if (local_off == `CWD_OFF_IOCTL) begin
      next_rdata = io_window_control;
    end else if (local_off >= `CWD_OFF_IO0_SL && local_off <= `CWD_OFF_IO1_EH) begin
      next_rdata = addr_byte[local_off[2:0]];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= `CWD_RESET_BYTE;
    end else if (reg_hit && !reg_wr) begin
      reg_rdata <= next_rdata;
    end
  end

  // card width pin is asynchronous to core_clk
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      is16_meta <= 1'b0;
      is16_sync <= 1'b0;
    end else begin
      is16_meta <= card_is16_pin;
      is16_sync <= is16_meta;
    end
  end

  always_comb begin
    next_claim = '0;
    if (io_req && win_hit[0]) begin
      next_claim.hit = 1'b1;
      next_claim.window = 1'b0;
      next_claim.wide = win_wide[0];
      next_claim.isa_cycles = win_cycles[0];
    end else if (io_req && win_hit[1]) begin
      next_claim.hit = 1'b1;
      next_claim.window = 1'b1;
      next_claim.wide = win_wide[1];
      next_claim.isa_cycles = win_cycles[1];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      io_claim <= '0;
    end else begin
      io_claim <= next_claim;
    end
  end

  assign mem_window_on = window_enable[4:0];

  // register side checks
  reset_clear_a: assert property (@(posedge core_clk) $rose(rst_b)
    |-> window_enable == `CWD_RESET_BYTE)
    else $error("enables not cleared after reset");
  ctl_reset_a: assert property (@(posedge core_clk) $rose(rst_b)
    |-> io_window_control == `CWD_RESET_BYTE && addr_byte[0] == `CWD_RESET_BYTE)
    else $error("control or address byte not cleared after reset");
  rsvd_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !window_enable[`CWD_BIT_RSVD])
    else $error("reserved enable bit set");
  rsvd_read_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_hit && !reg_wr && local_off == `CWD_OFF_ENABLE
    |=> !reg_rdata[`CWD_BIT_RSVD])
    else $error("reserved enable bit read as one");
  enable_wr_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_hit && reg_wr && local_off == `CWD_OFF_ENABLE
    |=> window_enable[`CWD_BIT_IO1_ON:`CWD_BIT_IO0_ON]
        == $past(reg_wdata[`CWD_BIT_IO1_ON:`CWD_BIT_IO0_ON])
        && window_enable[`CWD_BIT_RSVD-1:0] == $past(reg_wdata[`CWD_BIT_RSVD-1:0]))
    else $error("window enable write not stored");
  enable_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !(reg_hit && reg_wr && local_off == `CWD_OFF_ENABLE)
    |=> $stable(window_enable))
    else $error("window enable changed without a write");
  block_decode_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_hit == (reg_sel && reg_addr >= `CWD_SOCKET_BASE + 12'(`CWD_OFF_ENABLE)
                && reg_addr <= `CWD_SOCKET_BASE + 12'(`CWD_OFF_IO1_EH)))
    else $error("register decode outside the block window");
  ioctl_wr_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_hit && reg_wr && local_off == `CWD_OFF_IOCTL
    |=> io_window_control == $past(reg_wdata))
    else $error("i/o control write not stored");
  wr_back_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_hit && reg_wr && local_off == `CWD_OFF_IO1_SL
    |=> addr_byte[3'(`CWD_OFF_IO1_SL - `CWD_OFF_IO0_SL)] == $past(reg_wdata))
    else $error("start low byte not stored");
  addr_wr_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_hit && reg_wr && local_off >= `CWD_OFF_IO0_SL
    |=> addr_byte[$past(local_off[2:0])] == $past(reg_wdata))
    else $error("address byte not stored");
  end_high_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_hit && reg_wr && local_off == `CWD_OFF_IO0_EH
    |=> addr_byte[3'(`CWD_OFF_IO0_EH - `CWD_OFF_IO0_SL)] == $past(reg_wdata))
    else $error("end high byte not stored");
  end_low_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_hit && reg_wr && local_off == `CWD_OFF_IO1_EL
    |=> addr_byte[3'(`CWD_OFF_IO1_EL - `CWD_OFF_IO0_SL)] == $past(reg_wdata))
    else $error("end low byte not stored");
  rd_ioctl_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_hit && !reg_wr && local_off == `CWD_OFF_IOCTL
    |=> reg_rdata == $past(io_window_control))
    else $error("i/o control read back wrong");
  rd_addr_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_hit && !reg_wr && local_off >= `CWD_OFF_IO0_SL
    |=> reg_rdata == $past(addr_byte[local_off[2:0]]))
    else $error("address byte read back wrong");
  rdata_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !(reg_hit && !reg_wr) |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  // decode and cycle timing checks
  no_claim_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    io_claim.hit
    |-> (io_claim.window ? $past(window_enable[`CWD_BIT_IO1_ON])
                         : $past(window_enable[`CWD_BIT_IO0_ON])))
    else $error("claim by disabled window");
  no_req_claim_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !io_req |=> !io_claim.hit)
    else $error("claim without a host request");
  claim_hit_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    io_req && win_hit[0] |=> io_claim.hit && !io_claim.window)
    else $error("window 0 lost priority");
  win1_claim_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    io_req && win_hit[1] && !win_hit[0] |=> io_claim.hit && io_claim.window)
    else $error("window 1 hit not claimed");
  range0_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    io_claim.hit && !io_claim.window
    |-> $past(io_addr) >= $past(range[0].start_addr)
        && $past(io_addr) <= $past(range[0].end_addr))
    else $error("window 0 claim outside its range");
  range1_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    io_claim.hit && io_claim.window
    |-> $past(io_addr) >= $past(range[1].start_addr)
        && $past(io_addr) <= $past(range[1].end_addr))
    else $error("window 1 claim outside its range");
  short_cycle_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    io_claim.hit && !io_claim.wide && !io_claim.window
    && $past(io_window_control.io0_short_cycle)
    |-> io_claim.isa_cycles == `CWD_ISA_8_SHORT)
    else $error("short 8-bit cycle not three isa cycles");
  std8_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    io_claim.hit && !io_claim.wide && !io_claim.window
    && !$past(io_window_control.io0_short_cycle)
    |-> io_claim.isa_cycles == `CWD_ISA_8_STD)
    else $error("standard 8-bit cycle length wrong");
  short1_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    io_claim.hit && !io_claim.wide && io_claim.window
    && $past(io_window_control.io1_short_cycle)
    |-> io_claim.isa_cycles == `CWD_ISA_8_SHORT)
    else $error("window 1 short cycle wrong");
  long_cycle_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    io_claim.hit && io_claim.wide && !io_claim.window
    && $past(io_window_control.io0_extra_wait)
    |-> io_claim.isa_cycles == `CWD_ISA_16_LONG)
    else $error("16-bit wait not lengthened");
  std16_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    io_claim.hit && io_claim.wide && !io_claim.window
    && !$past(io_window_control.io0_extra_wait)
    |-> io_claim.isa_cycles == `CWD_ISA_16_STD)
    else $error("standard 16-bit cycle length wrong");
  long1_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    io_claim.hit && io_claim.wide && io_claim.window
    && $past(io_window_control.io1_extra_wait)
    |-> io_claim.isa_cycles == `CWD_ISA_16_LONG)
    else $error("window 1 wait not lengthened");
  width_src_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    io_req && win_hit[0] && !win_hit[1] && !io_window_control.io0_width_from_card
    |=> io_claim.wide == $past(io_window_control.io0_wide_select))
    else $error("width not from size bit");
  width_src1_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    io_req && !win_hit[0] && win_hit[1] && !io_window_control.io1_width_from_card
    |=> io_claim.wide == $past(io_window_control.io1_wide_select))
    else $error("window 1 width not from size bit");
  card_width_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    io_req && win_hit[0] && io_window_control.io0_width_from_card
    |=> io_claim.wide == $past(is16_sync))
    else $error("width not from card pin");
  card_width1_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    io_req && !win_hit[0] && win_hit[1] && io_window_control.io1_width_from_card
    |=> io_claim.wide == $past(is16_sync))
    else $error("window 1 width not from card pin");

  // scenario coverage
  cover_w0: cover property (@(posedge core_clk) disable iff (!rst_b)
    io_claim.hit && !io_claim.window);
  cover_w1: cover property (@(posedge core_clk) disable iff (!rst_b)
    io_claim.hit && io_claim.window);
  cover_overlap: cover property (@(posedge core_clk) disable iff (!rst_b)
    io_req && win_hit[0] && win_hit[1]);
  cover_wide: cover property (@(posedge core_clk) disable iff (!rst_b)
    io_claim.hit && io_claim.wide);
  cover_card_width: cover property (@(posedge core_clk) disable iff (!rst_b)
    io_req && win_hit[0] && io_window_control.io0_width_from_card);
endmodule // cwd_window_regs

// [test/cwd_card_model.sv]
// card side model driving the card 16-bit width indication
`timescale 1ns/1ps
module cwd_card_model (
  input wire logic core_clk,
  input wire logic wide_card,
  output logic card_is16_pin
);
  // level pin, changes just after an edge like a real card decode
  always @(posedge core_clk) begin
    card_is16_pin <= #1 wide_card;
  end
endmodule // cwd_card_model

// [test/card_window_enable_io_decode_tb.sv]
// testbench for the card window enable and i/o decode registers
`timescale 1ns/1ps
`include "cwd_params.svh"
module card_window_enable_io_decode_tb;
  import cwd_pkg::*;
  typedef struct packed {
    logic [7:0] ctl;
    logic card;
    logic [15:0] addr;
    cwd_claim_type exp;
  } cwd_row_type;
  logic core_clk = 0, rst_b = 0, reg_sel = 0, reg_wr = 0, io_req = 0, wide_card = 0;
  logic reg_hit, card_is16_pin;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [15:0] io_addr = 16'h0000;
  logic [4:0] mem_window_on;
  cwd_claim_type io_claim;
  cwd_row_type rows [15];
  logic [7:0] setv [16];
  int n_fail = 0, n_checks = 0;
  always #2 core_clk = ~core_clk;
  cwd_window_regs DUT (.core_clk(core_clk), .rst_b(rst_b), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .io_req(io_req), .io_addr(io_addr), .card_is16_pin(card_is16_pin), .io_claim(io_claim),
    .mem_window_on(mem_window_on));
  cwd_card_model u_card (.core_clk(core_clk), .wide_card(wide_card),
    .card_is16_pin(card_is16_pin));
  task wrap_up;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    reg_sel = 1; reg_wr = 1; reg_addr = a; reg_wdata = d;
    @(posedge core_clk); #1 reg_sel = 0; reg_wr = 0;
    @(posedge core_clk);
    #1;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e, input logic h);
    reg_sel = 1; reg_wr = 0; reg_addr = a;
    #1 chk({7'h00, reg_hit}, {7'h00, h});
    @(posedge core_clk); #1 reg_sel = 0;
    chk(reg_rdata, e);
    @(posedge core_clk);
    #1;
  endtask
  task io(input logic [15:0] a, input cwd_claim_type e);
    io_req = 1; io_addr = a;
    @(posedge core_clk); #1 io_req = 0;
    if (e.hit) chk({2'h0, io_claim}, {2'h0, e});
    else chk({7'h00, io_claim.hit}, 8'h00);
    @(posedge core_clk);
    #1;
  endtask
  initial begin
    #80000;
    n_fail++;
    wrap_up();
  end
  initial begin
    setv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'h00,
             8'h00, 8'h01, 8'hFF, 8'h01, 8'h80, 8'h01, 8'hFF, 8'h02};
    // win0 0100..01FF, win1 0180..02FF
    rows = '{{8'h00, 1'b0, 16'h0100, 6'h24}, {8'h04, 1'b0, 16'h01FF, 6'h23},
             {8'h01, 1'b0, 16'h0150, 6'h2A}, {8'h09, 1'b0, 16'h0150, 6'h2B},
             {8'h05, 1'b0, 16'h0150, 6'h2A}, {8'h08, 1'b0, 16'h0150, 6'h24},
             {8'h02, 1'b1, 16'h0150, 6'h2A}, {8'h03, 1'b0, 16'h0150, 6'h24},
             {8'h00, 1'b0, 16'h00FF, 6'h00}, {8'h00, 1'b0, 16'h0200, 6'h34},
             {8'h40, 1'b0, 16'h0250, 6'h33}, {8'h90, 1'b0, 16'h02FF, 6'h3B},
             {8'h00, 1'b0, 16'h0180, 6'h24}, {8'h00, 1'b0, 16'h0300, 6'h00},
             {8'h20, 1'b1, 16'h0200, 6'h3A}};
    repeat (10) @(posedge core_clk);
    #1 rst_b = 1;
    for (int i = 6; i < 16; i++) rd(`CWD_SOCKET_BASE + 12'(i), 8'h00, 1'b1);
    chk({3'h0, mem_window_on}, 8'h00);
    $display("reset values done");
    for (int i = 6; i < 16; i++) wr(`CWD_SOCKET_BASE + 12'(i), setv[i]);
    for (int i = 6; i < 16; i++) rd(`CWD_SOCKET_BASE + 12'(i), setv[i], 1'b1);
    $display("address bytes done");
    foreach (rows[i]) begin
      wr(12'h807, rows[i].ctl);
      wide_card = rows[i].card;
      repeat (4) @(posedge core_clk);
      #1 io(rows[i].addr, rows[i].exp);
    end
    rd(12'h807, 8'h20, 1'b1);
    $display("decode rows done");
    wr(12'h806, 8'hFF);
    rd(12'h806, 8'hDF, 1'b1);
    chk({3'h0, mem_window_on}, 8'h1F);
    wr(12'h806, 8'h00);
    io(16'h0150, 6'h00);
    io(16'h0200, 6'h00);
    wr(12'h806, 8'h40);
    io(16'h0200, 6'h00);
    io(16'h0150, 6'h24);
    chk({3'h0, mem_window_on}, 8'h00);
    wr(12'h806, 8'h80);
    io(16'h0150, 6'h00);
    io(16'h0180, 6'h3A);
    $display("enable bits done");
    rd(12'h805, 8'hDF, 1'b0);
    wr(12'h906, 8'h00);
    rd(12'h806, 8'h80, 1'b1);
    $display("unmapped access done");
    rst_b = 0;
    @(posedge core_clk);
    #1 rst_b = 1;
    rd(12'h806, 8'h00, 1'b1);
    rd(12'h80C, 8'h00, 1'b1);
    chk({3'h0, mem_window_on}, 8'h00);
    io(16'h0150, 6'h00);
    $display("second reset done");
    wrap_up();
  end
endmodule // card_window_enable_io_decode_tb
